// ---- hdl/cxp_defs.svh ----
// Constants for the coprocessor transfer port
`ifndef CXP_DEFS_SVH
`define CXP_DEFS_SVH

// Memory access cycle parameter, in clock cycles
`define CXP_ACCESS_CYC   4'h2
// Width of the cycle counter
`define CXP_CNT_W        4
// Number of coprocessor channels and channel number width
`define CXP_CHAN_N       16
`define CXP_CHAN_W       4
// Command word and data word widths
`define CXP_CMD_W        16
`define CXP_DATA_W       32
// Command word field layout
`define CXP_CC_W         8
`define CXP_FLD_W        4
// Extra cycles after the data phase, or after the command phase for operate
`define CXP_LS_TAIL      4'h0
`define CXP_OP_TAIL      4'h1
// Operation encodings
`define CXP_OP_LOAD      2'h0
`define CXP_OP_STORE     2'h1
`define CXP_OP_SAVE      2'h2
`define CXP_OP_OPERATE   2'h3

`endif

// ---- hdl/cxp_pkg.sv ----
// Types for the coprocessor transfer port
`include "cxp_defs.svh"

package cxp_pkg;

	// Instruction kinds
	typedef enum logic [1:0] {
		CXP_LOAD    = 2'h0,
		CXP_STORE   = 2'h1,
		CXP_SAVE    = 2'h2,
		CXP_OPERATE = 2'h3
	} cxp_op_type;

	// Sequencer states
	typedef enum logic [1:0] {
		CXP_IDLE = 2'h0,
		CXP_CMD  = 2'h1,
		CXP_DATA = 2'h2,
		CXP_FIN  = 2'h3
	} cxp_state_type;

	// Whole state of the port
	typedef struct packed {
		cxp_state_type               state;
		logic [`CXP_CNT_W-1:0]       cnt;
		cxp_op_type                  op;
		logic [`CXP_CHAN_N-1:0]      sel;
		logic [`CXP_CMD_W-1:0]       cmd;
		logic                        cmd_valid;
		logic [`CXP_DATA_W-1:0]      wdata;
		logic                        wdata_valid;
		logic                        rd_strobe;
		logic                        rf_we;
		logic [`CXP_FLD_W-1:0]       rf_waddr;
		logic [`CXP_DATA_W-1:0]      rf_wdata;
		logic                        trap_nf;
		logic                        trap_err;
		logic                        busy;
		logic                        done;
		logic                        flag_we;
	} cxp_regs_type;

endpackage : cxp_pkg

// ---- hdl/cxp_port.sv ----
// Coprocessor transfer port: command word then, except for operate, data word over the shared bus

`include "cxp_defs.svh"

module cxp_port (
	input  wire logic                   ref_clk_in,          // Core clock
	input  wire logic                   rst_n_in,            // Sync reset, low
	input  wire logic                   req_in,              // Start instruction
	input  wire cxp_pkg::cxp_op_type    op_in,               // Instruction kind
	input  wire logic [3:0]             channel_number_in,   // Target channel
	input  wire logic [7:0]             command_code_field_in, // Command code
	input  wire logic [3:0]             reg_field_hi_in,     // First register field
	input  wire logic [3:0]             reg_field_lo_in,     // Second register field
	input  wire logic [31:0]            src_data_in,         // CPU source register
	input  wire logic [15:0]            cp_present_in,       // Fitted per channel
	input  wire logic [15:0]            cp_error_in,         // Pending error per channel
	input  wire logic [31:0]            cp_rdata_in,         // Coprocessor output word
	output logic [15:0]                 cp_sel_out,          // One-hot channel select
	output logic [15:0]                 cp_cmd_out,          // Command word
	output logic                        cp_cmd_valid_out,    // Command phase
	output logic [31:0]                 cp_wdata_out,        // Data word to coprocessor
	output logic                        cp_wdata_valid_out,  // Write data phase
	output logic                        cp_rd_strobe_out,    // Read data phase
	output logic                        rf_we_out,           // CPU register write
	output logic [3:0]                  rf_waddr_out,        // CPU destination index
	output logic [31:0]                 rf_wdata_out,        // CPU destination data
	output logic                        trap_not_found_out,  // No coprocessor trap
	output logic                        trap_cop_error_out,  // Coprocessor error trap
	output logic                        busy_out,            // Instruction in progress
	output logic                        done_out,            // Instruction finished
	output logic                        flag_we_out          // Condition flag write
);
	import cxp_pkg::*;

	//--------------------------------------------------------------
	// State registers
	//--------------------------------------------------------------
	cxp_regs_type s_reg;
	cxp_regs_type s_next;

	logic chan_fitted;
	logic chan_error;
	logic err_trap;
	logic accept;

	// Channel lookup and trap decisions
	assign chan_fitted = cp_present_in[channel_number_in];
	assign chan_error  = cp_error_in[channel_number_in];
	assign err_trap    = chan_error && (op_in != CXP_SAVE);
	assign accept      = (s_reg.state == CXP_IDLE) && req_in && chan_fitted && !err_trap;

	//--------------------------------------------------------------
	// Next state
	//--------------------------------------------------------------
	// Sequencer and output generation
	always_comb begin
		s_next          = s_reg;
		s_next.trap_nf  = 1'b0;
		s_next.trap_err = 1'b0;
		s_next.done     = 1'b0;
		s_next.rf_we    = 1'b0;
		s_next.flag_we  = 1'b0;
		case (s_reg.state)
			CXP_IDLE: begin
				if (req_in) begin
					if (!chan_fitted) begin
						s_next.trap_nf = 1'b1;
					end else if (err_trap) begin
						s_next.trap_err = 1'b1;
					end else begin
						s_next.state     = CXP_CMD;
						s_next.cnt       = `CXP_ACCESS_CYC - 4'h1;
						s_next.op        = op_in;
						s_next.busy      = 1'b1;
						s_next.cmd_valid = 1'b1;
						s_next.cmd       = {command_code_field_in, reg_field_hi_in,
						                    reg_field_lo_in};
						s_next.wdata     = src_data_in;
						s_next.rf_waddr  = reg_field_lo_in;
						s_next.sel       = 16'h0001 << channel_number_in;
					end
				end
			end
			CXP_CMD: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					s_next.cmd_valid = 1'b0;
					if (s_reg.op == CXP_OPERATE) begin
						s_next.state = CXP_FIN;
						s_next.cnt   = `CXP_OP_TAIL;
						s_next.done  = (`CXP_OP_TAIL == 4'h0);
					end else begin
						// data word follows on the bus
						s_next.state       = CXP_DATA;
						s_next.cnt         = `CXP_ACCESS_CYC - 4'h1;
						s_next.wdata_valid = (s_reg.op == CXP_LOAD);
						s_next.rd_strobe   = (s_reg.op != CXP_LOAD);
					end
				end
			end
			CXP_DATA: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					if (s_reg.op != CXP_LOAD) begin
						s_next.rf_we    = 1'b1;
						s_next.rf_wdata = cp_rdata_in;
					end
					s_next.wdata_valid = 1'b0;
					s_next.rd_strobe   = 1'b0;
					s_next.state       = CXP_FIN;
					s_next.cnt         = `CXP_LS_TAIL;
					// done lands in the final cycle, with the write
					s_next.done        = (`CXP_LS_TAIL == 4'h0);
				end
			end
			CXP_FIN: begin
				if (s_reg.cnt != 4'h0) begin
					s_next.cnt = s_reg.cnt - 4'h1;
				end else begin
					s_next.state = CXP_IDLE;
					s_next.busy  = 1'b0;
					s_next.sel   = 16'h0000;
				end
				s_next.done = (s_reg.cnt == 4'h1);
			end
			default: begin
				s_next.state = CXP_IDLE;
			end
		endcase
	end

	// State register with synchronous reset
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	//--------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------
	// Straight from the state flops
	assign cp_sel_out         = s_reg.sel;
	assign cp_cmd_out         = s_reg.cmd;
	assign cp_cmd_valid_out   = s_reg.cmd_valid;
	assign cp_wdata_out       = s_reg.wdata;
	assign cp_wdata_valid_out = s_reg.wdata_valid;
	assign cp_rd_strobe_out   = s_reg.rd_strobe;
	assign rf_we_out          = s_reg.rf_we;
	assign rf_waddr_out       = s_reg.rf_waddr;
	assign rf_wdata_out       = s_reg.rf_wdata;
	assign trap_not_found_out = s_reg.trap_nf;
	assign trap_cop_error_out = s_reg.trap_err;
	assign busy_out           = s_reg.busy;
	assign done_out           = s_reg.done;
	assign flag_we_out        = s_reg.flag_we;

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	localparam int ACC    = `CXP_ACCESS_CYC;
	localparam int LS_CYC = 1 + 2 * ACC;
	localparam int OP_CYC = 2 + ACC;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_not_found;
		(s_reg.state == CXP_IDLE) && req_in && !chan_fitted
		|=> trap_not_found_out && !cp_cmd_valid_out && !busy_out;
	endproperty
	a_not_found: assert property (p_not_found)
		else $error("missing coprocessor did not trap");

	property p_error_trap;
		(s_reg.state == CXP_IDLE) && req_in && chan_fitted && chan_error &&
		(op_in != CXP_SAVE) |=> trap_cop_error_out && !cp_cmd_valid_out;
	endproperty
	a_error_trap: assert property (p_error_trap)
		else $error("pending error did not trap");

	property p_save_no_trap;
		(s_reg.state == CXP_IDLE) && req_in && chan_fitted && (op_in == CXP_SAVE)
		|=> !trap_cop_error_out && cp_cmd_valid_out;
	endproperty
	a_save_no_trap: assert property (p_save_no_trap)
		else $error("save raised error trap");

	property p_load_seq;
		accept && (op_in == CXP_LOAD)
		|=> cp_cmd_valid_out && (cp_wdata_out == $past(src_data_in))
		##ACC cp_wdata_valid_out && !cp_cmd_valid_out;
	endproperty
	a_load_seq: assert property (p_load_seq)
		else $error("load data word not sent after command");

	property p_store_write;
		accept && (op_in == CXP_STORE) |-> ##LS_CYC rf_we_out && done_out;
	endproperty
	a_store_write: assert property (p_store_write)
		else $error("store did not write CPU register");

	property p_ls_len;
		accept && (op_in != CXP_OPERATE)
		|-> ##1 (!done_out) [*4] ##(LS_CYC - 4) done_out;
	endproperty
	a_ls_len: assert property (p_ls_len)
		else $error("transfer length wrong");

	property p_op_len;
		accept && (op_in == CXP_OPERATE)
		|-> ##OP_CYC done_out && !rf_we_out;
	endproperty
	a_op_len: assert property (p_op_len)
		else $error("operate length wrong");

	property p_sel;
		cp_cmd_valid_out |-> $onehot(cp_sel_out);
	endproperty
	a_sel: assert property (p_sel)
		else $error("channel select not one-hot");

	property p_trap_quiet;
		trap_not_found_out || trap_cop_error_out
		|-> !rf_we_out && !cp_wdata_valid_out && !cp_rd_strobe_out;
	endproperty
	a_trap_quiet: assert property (p_trap_quiet)
		else $error("trap with transfer or write");

	property p_flags;
		busy_out |-> !flag_we_out;
	endproperty
	a_flags: assert property (p_flags)
		else $error("flags written by transfer");

endmodule : cxp_port

// ---- verif/cxp_cp_model.sv ----
// Behavioural coprocessor on the far side of the transfer port
module cxp_cp_model (
	input  wire logic        ref_clk_in,         // Core clock
	input  wire logic [15:0] cp_sel_in,          // Channel select
	input  wire logic [15:0] cp_cmd_in,          // Command word
	input  wire logic        cp_cmd_valid_in,    // Command phase
	input  wire logic [31:0] cp_wdata_in,        // Load data word
	input  wire logic        cp_wdata_valid_in,  // Load data phase
	input  wire logic        cp_rd_strobe_in,    // Read data phase
	output logic      [31:0] cp_rdata_out        // Output word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] cr_reg [16];
	logic [15:0] cmd_reg;
	logic [31:0] last_reg = 32'h0;
	logic        cv_prev  = 1'b0;
	// Single-precision word to real, normal numbers and zero only
	function automatic real sp_to_real(input logic [31:0] w);
		logic [10:0] e;
		e = {3'h0, w[30:23]} + 11'h380;
		return (w[30:0] == 31'h0) ? $bitstoreal({w[31], 63'h0}) :
		       $bitstoreal({w[31], e, w[22:0], 29'h0});
	endfunction : sp_to_real
	// Real back to a single-precision word, truncating
	function automatic logic [31:0] real_to_sp(input real r);
		logic [63:0] d;
		logic [10:0] e;
		d = $realtobits(r);
		e = d[62:52] - 11'h380;
		return (d[62:0] == 63'h0) ? {d[63], 31'h0} : {d[63], e[7:0], d[51:29]};
	endfunction : real_to_sp
	// float unit: codes 00 to 03 calculate, others leave the register
	function automatic logic [31:0] calc(input logic [7:0] code, input logic [31:0] a, b);
		logic [31:0] res;
		res = a;
		case (code)
			8'h00: res = real_to_sp(sp_to_real(a) + sp_to_real(b));
			8'h01: res = real_to_sp(sp_to_real(a) - sp_to_real(b));
			8'h02: res = real_to_sp(sp_to_real(a) * sp_to_real(b));
			8'h03: res = real_to_sp(sp_to_real(a) / sp_to_real(b));
			default: res = a;
		endcase
		return res;
	endfunction : calc
	// decode command and load named register
	always @(posedge ref_clk_in) begin
		if (cp_cmd_valid_in && cp_sel_in != 16'h0)
			cmd_reg <= cp_cmd_in;
		if (cp_wdata_valid_in && cp_sel_in != 16'h0)
			cr_reg[cmd_reg[3:0]] <= cp_wdata_in;
		if (cp_rd_strobe_in)
			last_reg <= cp_rdata_out;
		// operate on channel 15: command phase with no data phase
		if (cv_prev && !cp_cmd_valid_in && !cp_wdata_valid_in && !cp_rd_strobe_in &&
		    cp_sel_in[15])
			cr_reg[cmd_reg[3:0]] <= calc(cmd_reg[15:8], cr_reg[cmd_reg[3:0]],
			                             cr_reg[cmd_reg[7:4]]);
		cv_prev <= cp_cmd_valid_in;
	end
	// drive source register, scrambled when released
	assign cp_rdata_out = cp_rd_strobe_in ? cr_reg[cmd_reg[7:4]] : ~last_reg;
endmodule : cxp_cp_model

// ---- verif/tb_cxp_port.sv ----
// Self-checking bench for the coprocessor transfer port
`include "cxp_defs.svh"
`define CHK(g,e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_cxp_port;
	timeunit 1ns;
	timeprecision 1ps;
	import cxp_pkg::*;
	localparam int LS = 1 + 2 * `CXP_ACCESS_CYC;
	localparam int OPC = 2 + `CXP_ACCESS_CYC;
	logic ref_clk = 0, rst_n = 0, req = 0;
	cxp_op_type op_r = CXP_LOAD;
	logic [3:0] ch_r = 0, hi_r = 0, lo_r = 0;
	logic [7:0] cc_r = 8'h04, cc_w = 8'h04;
	logic [31:0] src = 0, rdata, wdata, rf_wd, gwd;
	logic [15:0] pres = 16'hefff, err = 16'h0, sel, cmd, gsel, gcmd;
	logic cv, wv, rs, we, nf, ce, busy, done, fwe, gwe, gnf, gerr, gflag;
	logic [3:0] rf_wa, gwa;
	int gcyc, fail_count = 0, compares = 0;
	cxp_port i_cxp_port (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .req_in(req), .op_in(op_r),
		.channel_number_in(ch_r), .command_code_field_in(cc_r), .reg_field_hi_in(hi_r),
		.reg_field_lo_in(lo_r), .src_data_in(src), .cp_present_in(pres), .cp_error_in(err),
		.cp_rdata_in(rdata), .cp_sel_out(sel), .cp_cmd_out(cmd), .cp_cmd_valid_out(cv),
		.cp_wdata_out(wdata), .cp_wdata_valid_out(wv), .cp_rd_strobe_out(rs),
		.rf_we_out(we), .rf_waddr_out(rf_wa), .rf_wdata_out(rf_wd),
		.trap_not_found_out(nf), .trap_cop_error_out(ce), .busy_out(busy),
		.done_out(done), .flag_we_out(fwe));
	cxp_cp_model i_cxp_cp_model (.ref_clk_in(ref_clk), .cp_sel_in(sel), .cp_cmd_in(cmd),
		.cp_cmd_valid_in(cv), .cp_wdata_in(wdata), .cp_wdata_valid_in(wv),
		.cp_rd_strobe_in(rs), .cp_rdata_out(rdata));
	// Clock generation
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// Issue one instruction and record what the port does until it ends
	task automatic run_op(input cxp_op_type o, input logic [3:0] c, h, l, input logic [31:0] d);
		@(posedge ref_clk);
		req <= 1'b1; op_r <= o; ch_r <= c; hi_r <= h; lo_r <= l; src <= d;
		cc_r <= cc_w;
		@(posedge ref_clk);
		req <= 1'b0;
		gcyc = 0; gwe = 0; gnf = 0; gerr = 0; gflag = 0; gsel = 0; gcmd = 0;
		for (int n = 1; n <= 20 && gcyc == 0; n++) begin
			#1;
			if (sel !== 16'h0) gsel = sel;
			if (cv === 1'b1) gcmd = cmd;
			if (we === 1'b1) begin gwe = 1; gwd = rf_wd; gwa = rf_wa; end
			if (nf === 1'b1) gnf = 1;
			if (ce === 1'b1) gerr = 1;
			if (fwe !== 1'b0) gflag = 1;
			if (done === 1'b1 || gnf || gerr) gcyc = n;
			else @(posedge ref_clk);
		end
		if (gcyc == 0) begin fail_count++; final_report(); end
	endtask : run_op
	// Load then store back-to-back on channel 3
	task automatic test_load_store();
		run_op(CXP_LOAD, 4'h3, 4'h8, 4'h5, 32'ha5c3_1e07);
		`CHK(gcyc, LS)
		`CHK(gcmd, 16'h0485)
		`CHK(gsel, 16'h0008)
		`CHK({gwe, gflag}, 2'b00)
		run_op(CXP_STORE, 4'h3, 4'h5, 4'h9, 32'h0);
		`CHK(gcyc, LS)
		`CHK({gwe, gwa, gwd}, {1'b1, 4'h9, 32'ha5c3_1e07})
		`CHK(gflag, 1'b0)
		$display("test_load_store done");
	endtask : test_load_store
	// Pending error traps load, store and operate but not save
	task automatic test_error();
		@(posedge ref_clk); err <= 16'h1008;
		run_op(CXP_STORE, 4'h3, 4'h5, 4'h9, 32'h0);
		`CHK({gerr, gwe, gcyc}, {1'b1, 1'b0, 32'd1})
		run_op(CXP_LOAD, 4'h3, 4'h1, 4'h5, 32'h1234_5678);
		`CHK({gerr, gsel, gcyc}, {1'b1, 16'h0, 32'd1})
		run_op(CXP_SAVE, 4'h3, 4'h5, 4'h2, 32'h0);
		`CHK({gerr, gnf, gcyc}, {2'b00, LS})
		`CHK({gwe, gwa, gwd}, {1'b1, 4'h2, 32'ha5c3_1e07})
		run_op(CXP_OPERATE, 4'h3, 4'h1, 4'h2, 32'h0);
		`CHK(gerr, 1'b1)
		$display("test_error done");
	endtask : test_error
	// Missing coprocessor traps every instruction kind
	task automatic test_not_found();
		for (int i = 0; i < 4; i++) begin
			run_op(cxp_op_type'(i), 4'hc, 4'h1, 4'h2, 32'h0);
			`CHK({gnf, gerr, gcyc}, {2'b10, 32'd1})
			`CHK({gwe, gsel}, {1'b0, 16'h0})
		end
		$display("test_not_found done");
	endtask : test_not_found
	// Operate sends command only
	task automatic test_operate();
		@(posedge ref_clk); err <= 16'h0;
		run_op(CXP_OPERATE, 4'hf, 4'h3, 4'h4, 32'h0);
		`CHK({gcyc, gsel, gcmd}, {OPC, 16'h8000, 16'h0434})
		`CHK({gwe, gflag}, 2'b00)
		$display("test_operate done");
	endtask : test_operate
	// Float unit on channel 15 works on its own registers per command code
	task automatic test_float();
		logic [159:0] exp_w;
		exp_w = {32'h4000_0000, 32'h4000_0000, 32'h4040_0000, 32'h4000_0000, 32'h4060_0000};
		run_op(CXP_LOAD, 4'hf, 4'h0, 4'h1, 32'h4000_0000);
		run_op(CXP_LOAD, 4'hf, 4'h0, 4'h2, 32'h3fc0_0000);
		for (int k = 0; k < 5; k++) begin
			cc_w = k[7:0];
			run_op(CXP_OPERATE, 4'hf, 4'h2, 4'h1, 32'h0);
			`CHK(gcmd, {k[7:0], 8'h21})
			cc_w = 8'h04;
			run_op(CXP_STORE, 4'hf, 4'h1, 4'h6, 32'h0);
			`CHK(gwd, exp_w[32*k +: 32])
		end
		$display("test_float done");
	endtask : test_float
	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		`CHK({busy, done, sel}, 18'h0)
		test_load_store();
		test_error();
		test_not_found();
		test_operate();
		test_float();
		final_report();
	end
endmodule : tb_cxp_port
